// >>> dv/sfi_master.sv
`timescale 1ns/10ps
module sfi_master (
	// serial link
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_i
);
	logic [7:0] tx [0:31];
	logic [7:0] rx [0:31];
	logic cpol;
	logic oe_seen;
	// select starts low, as a board may leave it at power-up
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b0;
		si_o = 1'b0;
		cpol = 1'b0;
		oe_seen = 1'b0;
	end
	// data settles in the low half, taken by the device at the rise
	task automatic bits(input int n);
		for (int i = 0; i < n * 8; i++) begin
			sck_o = 1'b0;
			si_o = tx[i / 8][7 - i % 8];
			#62.5;
			sck_o = 1'b1;
			// undriven line reads back as garbage, never as the last value
			rx[i / 8][7 - i % 8] = so_oe_i ? so_i : ~so_i;
			oe_seen = oe_seen | so_oe_i;
			#62.5;
		end
	endtask
	task automatic frame(input int n);
		sck_o = cpol;
		cs_n_o = 1'b0;
		#62.5;
		bits(n);
		sck_o = cpol;
		#62.5;
		cs_n_o = 1'b1;
		si_o = ~si_o;
		#250;
	endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
	import sfi_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic res_n = 1'b1;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic busy;
	logic stby;
	int bad_count = 0;
	int n_tests = 0;
	logic [7:0] mdl [int];
	always #4 clk = ~clk;
	// small array keeps the simulator light; top half lies above the protected range
	sfi_top #(.ADDR_W(17)) i_dut (.CLK_I(clk), .SYS_RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
		.SO_O(so), .SO_OE_O(so_oe), .WP_N_I(wp_n), .RESET_N_I(res_n), .BUSY_O(busy), .STANDBY_O(stby));
	sfi_master i_mst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(so) begin
		if (so_oe === 1'b1 && sck !== 1'b0) begin
			bad_count++;
			$display("FAIL so edge expected 0 seen %b", sck);
		end
	end
	function automatic logic [7:0] get(input int a);
		return mdl.exists(a) ? mdl[a] : SFI_ERASED;
	endfunction
	task automatic send(input logic [7:0] op, input logic [23:0] a, input int n);
		i_mst.tx[0] = op;
		i_mst.tx[1] = a[23:16];
		i_mst.tx[2] = a[15:8];
		i_mst.tx[3] = a[7:0];
		i_mst.frame(n);
	endtask
	task automatic wr(input logic [7:0] op, input logic [23:0] a, input int nd);
		logic ok;
		int p;
		int q;
		ok = wp_n || (a[20:16] != 5'h0);
		p = {a[23:8], 8'h00};
		send(SFI_OP_WREN, 24'h0, 1);
		send(op, a, 4 + nd);
		repeat (4) @(posedge clk);
		chk("busy", {7'h0, ok}, {7'h0, busy});
		chk("standby", {7'h0, !ok}, {7'h0, stby});
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk("standby idle", 8'h1, {7'h0, stby});
		if (ok && op == SFI_OP_PE) for (int i = 0; i < 256; i++) mdl[p + i] = SFI_ERASED;
		if (ok && op != SFI_OP_PE) for (int i = 0; i < nd; i++) begin
			q = p + ((a + i) & 255);
			mdl[q] = (op == SFI_OP_PW) ? i_mst.tx[4 + i] : (get(q) & i_mst.tx[4 + i]);
		end
	endtask
	task automatic rd(input logic [23:0] a, input int n);
		send(SFI_OP_READ, a, 4 + n);
		for (int i = 0; i < n; i++) chk("read", get(a + i), i_mst.rx[4 + i]);
	endtask
	task automatic s_power_up();
		i_mst.tx[0] = SFI_OP_READ;
		i_mst.bits(5);
		i_mst.cs_n_o = 1'b1;
		repeat (6) @(posedge clk);
		chk("oe before select fall", 8'h0, {7'h0, i_mst.oe_seen});
		chk("oe deselected", 8'h0, {7'h0, so_oe});
		chk("standby", 8'h1, {7'h0, stby});
	endtask
	task automatic s_erase_prog();
		wr(SFI_OP_PE, 24'h011000, 0);
		rd(24'h0110f0, 16);
		for (int i = 0; i < 16; i++) i_mst.tx[4 + i] = 8'ha0 + i;
		// start near the page end so the data index wraps
		wr(SFI_OP_PP, 24'h0110f8, 16);
		rd(24'h0110f0, 16);
		rd(24'h011000, 12);
		i_mst.tx[4] = 8'h5c;
		i_mst.tx[5] = 8'hff;
		// ff over ac only shows if the page was erased first
		wr(SFI_OP_PW, 24'h011003, 2);
		rd(24'h011000, 8);
		i_mst.cpol = 1'b1;
		rd(24'h011000, 4);
		i_mst.cpol = 1'b0;
	endtask
	task automatic s_protect();
		wr(SFI_OP_PE, 24'h000000, 0);
		wp_n <= 1'b0;
		repeat (4) @(posedge clk);
		i_mst.tx[4] = 8'h00;
		wr(SFI_OP_PP, 24'h000020, 1);
		wr(SFI_OP_PE, 24'h00ff00, 0);
		wr(SFI_OP_SE, 24'h000000, 0);
		rd(24'h00001e, 4);
		wr(SFI_OP_PE, 24'h010000, 0);
		rd(24'h010000, 4);
		wp_n <= 1'b1;
		repeat (4) @(posedge clk);
		i_mst.tx[4] = 8'h00;
		wr(SFI_OP_PP, 24'h000020, 1);
		rd(24'h00001e, 4);
	endtask
	task automatic s_reset_abort();
		send(SFI_OP_WREN, 24'h0, 1);
		send(SFI_OP_PE, 24'h012000, 4);
		chk("busy before abort", 8'h1, {7'h0, busy});
		// status mid-cycle: write enable still set, busy set
		send(SFI_OP_RDSR, 24'h0, 2);
		chk("status", 8'h03, i_mst.rx[1]);
		chk("busy at status", 8'h1, {7'h0, busy});
		@(posedge clk);
		res_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk("busy after abort", 8'h0, {7'h0, busy});
		i_mst.oe_seen = 1'b0;
		send(SFI_OP_READ, 24'h011000, 5);
		chk("oe in reset", 8'h0, {7'h0, i_mst.oe_seen});
		@(posedge clk);
		res_n <= 1'b1;
		repeat (5) @(posedge clk);
		rd(24'h011000, 4);
	endtask
	initial begin
		// about twice the expected run, exactly 50k clocks
		#400000;
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		s_power_up();
		s_erase_prog();
		s_protect();
		s_reset_abort();
		give_verdict();
	end
endmodule

// >>> hw/sfi_fifo.sv
`timescale 1ns/10ps
module sfi_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	// depth must be a power of two so the pointers wrap naturally
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready_o = cnt_r != FULL;
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem_r[rd_r];

	always_comb begin
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wr_nxt = push ? wr_r + PW'(1) : wr_r;
		rd_nxt = pop ? rd_r + PW'(1) : rd_r;
		cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end
endmodule

// >>> hw/sfi_pkg.sv
package sfi_pkg;
	// array geometry
	localparam int SFI_ADDR_W = 21;
	localparam int SFI_PAGE_W = 8;
	localparam int SFI_SECT_W = 16;
	localparam int SFI_PROT_W = 16;
	localparam int SFI_FIFO_DEPTH = 4;
	localparam logic [7:0] SFI_ERASED = 8'hff;
	// serial frame layout, counted in bytes
	localparam logic [2:0] SFI_BYTE_OP = 3'h0;
	localparam logic [2:0] SFI_BYTE_WREN_END = 3'h1;
	localparam logic [2:0] SFI_BYTE_ADDR_LAST = 3'h3;
	localparam logic [2:0] SFI_BYTE_DATA = 3'h4;
	localparam logic [2:0] SFI_BIT_LAST = 3'h7;
	// instruction codes
	localparam logic [7:0] SFI_OP_WREN = 8'h06;
	localparam logic [7:0] SFI_OP_RDSR = 8'h05;
	localparam logic [7:0] SFI_OP_READ = 8'h03;
	localparam logic [7:0] SFI_OP_PW = 8'h0a;
	localparam logic [7:0] SFI_OP_PP = 8'h02;
	localparam logic [7:0] SFI_OP_PE = 8'hdb;
	localparam logic [7:0] SFI_OP_SE = 8'hd8;

	typedef struct packed {
		logic rst_n;
		logic wp_n;
		logic si;
		logic cs_n;
		logic sck;
	} sfi_pins_t;

	typedef struct packed {
		logic [SFI_PAGE_W-1:0] idx;
		logic [7:0] data;
	} sfi_word_t;

	typedef enum logic [1:0] {
		SFI_IDLE,
		SFI_LOAD,
		SFI_ERASE,
		SFI_PROG
	} sfi_cyc_t;
endpackage

// >>> hw/sfi_top.sv
`timescale 1ns/10ps
// Contract
// - The array holds 16 Mbit as 2M byte-wide locations reached only through the serial link.
// - One page rewrite or page program changes from 1 to 256 bytes, all inside one page.
// - Page rewrite runs an erase of the addressed page and then a program of it on its own.
// - The array is 32 sectors of 256 pages of 256 bytes, 8192 pages in all.
// - Erase works on one page (page erase) or on one whole sector (block erase).
// - Each output bit is shifted out on the falling serial clock edge.
// - The master drives command, address and data on the input pin, sampled on each rising clock edge.
// - While select is high the device is deselected and its output is not driven.
// - Deselected, the device enters standby only once no internal cycle runs; select low makes it active.
// - After power-up nothing is accepted before a falling edge on select.
// - While the reset pin is low the device sits in reset with its output not driven.
// - Reset low during an internal write, program or erase aborts it and leaves its bytes undefined.
// - With protect low every write, program or erase aimed at the lowest 256 pages is refused.
// - With protect high the lowest 256 pages behave like all others.
module sfi_top #(
	parameter int ADDR_W = sfi_pkg::SFI_ADDR_W
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// serial link
	input wire logic SCK_I,
	input wire logic CS_N_I,
	input wire logic SI_I,
	output logic SO_O,
	output logic SO_OE_O,
	// control pins
	input wire logic WP_N_I,
	input wire logic RESET_N_I,
	// status
	output logic BUSY_O,
	output logic STANDBY_O
);
	import sfi_pkg::*;

	sfi_pins_t meta_r, sync_r;
	logic sck_d_r, cs_d_r;
	logic sck_rise, sck_fall, cs_fall, cs_rise;

	// frame group
	logic frame_r, frame_nxt, ndata_r, ndata_nxt, ovf_r, ovf_nxt, wel_r, wel_nxt, pend_r, pend_nxt;
	logic fetch_r, fetch_nxt, ld_r, ld_nxt, so_r, so_nxt;
	logic [2:0] bit_r, bit_nxt, byte_r, byte_nxt;
	logic [7:0] sh_r, sh_nxt, op_r, op_nxt, tx_r, tx_nxt, byte_v, cur_op;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic push;

	// internal cycle group
	sfi_cyc_t cyc_r, cyc_nxt;
	logic [SFI_SECT_W-1:0] idx_r, idx_nxt;
	logic [ADDR_W-1:0] base_r, base_nxt, waddr, rd_addr;
	logic [7:0] cop_r, cop_nxt;
	logic sect_r, sect_nxt, ph_r, ph_nxt, last, prot, cyc_start, cyc_refuse, cyc_done;
	logic mem_we, buf_ld;
	logic [7:0] mem_wd;

	// storage and staging
	logic [7:0] mem_r [2**ADDR_W];
	logic [7:0] buf_r [2**SFI_PAGE_W];
	logic [2**SFI_PAGE_W-1:0] mask_r;
	logic [7:0] mem_q, buf_q;
	sfi_word_t push_word, drain_word;
	logic fifo_in_ready, fifo_out_valid, drain;

	// pins and the link clock cross into CLK_I domain here
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			meta_r <= '0;
			sync_r <= '0;
			sck_d_r <= 1'b0;
			// cs history resets low so select already low at release is no falling edge
			cs_d_r <= 1'b0;
		end else begin
			meta_r <= '{rst_n: RESET_N_I, wp_n: WP_N_I, si: SI_I, cs_n: CS_N_I, sck: SCK_I};
			sync_r <= meta_r;
			sck_d_r <= sync_r.sck;
			cs_d_r <= sync_r.cs_n;
		end
	end

	// either idle level works; only edges are used
	assign sck_rise = sync_r.sck && !sck_d_r;
	assign sck_fall = !sync_r.sck && sck_d_r;
	assign cs_fall = !sync_r.cs_n && cs_d_r;
	assign cs_rise = sync_r.cs_n && !cs_d_r;

	always_comb begin
		frame_nxt = frame_r;
		bit_nxt = bit_r;
		byte_nxt = byte_r;
		sh_nxt = sh_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		ndata_nxt = ndata_r;
		ovf_nxt = ovf_r;
		wel_nxt = wel_r;
		pend_nxt = pend_r;
		tx_nxt = tx_r;
		so_nxt = so_r;
		fetch_nxt = 1'b0;
		ld_nxt = fetch_r;
		push = 1'b0;
		byte_v = {sh_r[6:0], sync_r.si};
		cur_op = (byte_r == SFI_BYTE_OP) ? byte_v : op_r;
		push_word = '{idx: addr_r[SFI_PAGE_W-1:0], data: byte_v};
		if (fetch_r) begin
			addr_nxt = addr_r + ADDR_W'(1);
		end
		if (ld_r) begin
			tx_nxt = mem_q;
		end
		if (cs_fall) begin
			// a frame opens only on a seen falling edge of select
			frame_nxt = 1'b1;
			bit_nxt = '0;
			byte_nxt = SFI_BYTE_OP;
			ndata_nxt = 1'b0;
			ovf_nxt = 1'b0;
		end else if (cs_rise) begin
			frame_nxt = 1'b0;
			// partial bytes void the frame
			if (frame_r && bit_r == '0 && cyc_r == SFI_IDLE && !pend_r) begin
				if (op_r == SFI_OP_WREN && byte_r == SFI_BYTE_WREN_END) begin
					wel_nxt = 1'b1;
				end
				if (wel_r && byte_r == SFI_BYTE_DATA &&
					(((op_r == SFI_OP_PW || op_r == SFI_OP_PP) && ndata_r && !ovf_r) ||
					((op_r == SFI_OP_PE || op_r == SFI_OP_SE) && !ndata_r))) begin
					pend_nxt = 1'b1;
				end
			end
		end else if (frame_r && sck_rise) begin
			sh_nxt = byte_v;
			bit_nxt = bit_r + 3'h1;
			if (bit_r == SFI_BIT_LAST) begin
				if (byte_r != SFI_BYTE_DATA) begin
					byte_nxt = byte_r + 3'h1;
				end
				if (byte_r == SFI_BYTE_OP) begin
					op_nxt = byte_v;
				end else if (byte_r != SFI_BYTE_DATA) begin
					addr_nxt = {addr_r[ADDR_W-9:0], byte_v};
				end else begin
					ndata_nxt = 1'b1;
					if ((op_r == SFI_OP_PW || op_r == SFI_OP_PP) && cyc_r == SFI_IDLE) begin
						// index wraps inside the page, later bytes overwrite earlier
						push = 1'b1;
						ovf_nxt = ovf_r || !fifo_in_ready;
						addr_nxt[SFI_PAGE_W-1:0] = addr_r[SFI_PAGE_W-1:0] + SFI_PAGE_W'(1);
					end
				end
				if (cur_op == SFI_OP_RDSR) begin
					tx_nxt = {6'h00, wel_r, cyc_r != SFI_IDLE};
				end
				// array port belongs to the internal cycle while one runs
				if (cur_op == SFI_OP_READ && byte_r >= SFI_BYTE_ADDR_LAST && cyc_r == SFI_IDLE) begin
					fetch_nxt = 1'b1;
				end
			end
		end
		if (frame_r && sck_fall) begin
			so_nxt = tx_r[7];
			tx_nxt = {tx_r[6:0], 1'b0};
		end
		if (cyc_start || cyc_refuse) begin
			pend_nxt = 1'b0;
		end
		if (cyc_refuse || cyc_done) begin
			wel_nxt = 1'b0;
		end
		if (!sync_r.rst_n) begin
			frame_nxt = 1'b0;
			pend_nxt = 1'b0;
			wel_nxt = 1'b0;
			fetch_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			frame_r <= 1'b0;
			bit_r <= '0;
			byte_r <= SFI_BYTE_OP;
			sh_r <= '0;
			op_r <= '0;
			addr_r <= '0;
			ndata_r <= 1'b0;
			ovf_r <= 1'b0;
			wel_r <= 1'b0;
			pend_r <= 1'b0;
			tx_r <= '0;
			so_r <= 1'b0;
			fetch_r <= 1'b0;
			ld_r <= 1'b0;
		end else begin
			frame_r <= frame_nxt;
			bit_r <= bit_nxt;
			byte_r <= byte_nxt;
			sh_r <= sh_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			ndata_r <= ndata_nxt;
			ovf_r <= ovf_nxt;
			wel_r <= wel_nxt;
			pend_r <= pend_nxt;
			tx_r <= tx_nxt;
			so_r <= so_nxt;
			fetch_r <= fetch_nxt;
			ld_r <= ld_nxt;
		end
	end

	// bytes cross to the page buffer; drain stalls while an internal cycle owns the buffer
	sfi_fifo #(.WIDTH($bits(sfi_word_t)), .DEPTH(SFI_FIFO_DEPTH)) u_fifo (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_word),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(cyc_r == SFI_IDLE),
		.out_data_o(drain_word)
	);
	assign drain = fifo_out_valid && cyc_r == SFI_IDLE;

	always_comb begin
		cyc_nxt = cyc_r;
		idx_nxt = idx_r;
		base_nxt = base_r;
		cop_nxt = cop_r;
		sect_nxt = sect_r;
		ph_nxt = ph_r;
		mem_we = 1'b0;
		mem_wd = SFI_ERASED;
		buf_ld = 1'b0;
		cyc_done = 1'b0;
		prot = !sync_r.wp_n && addr_r[ADDR_W-1:SFI_PROT_W] == '0;
		cyc_start = pend_r && !fifo_out_valid && cyc_r == SFI_IDLE && sync_r.rst_n && !prot;
		cyc_refuse = pend_r && !fifo_out_valid && cyc_r == SFI_IDLE && prot;
		waddr = base_r | ADDR_W'(idx_r);
		// page walks stop at 256 bytes, sector walks at 256 pages
		last = sect_r ? idx_r == '1 : idx_r[SFI_PAGE_W-1:0] == '1;
		if (cyc_start) begin
			cop_nxt = op_r;
			sect_nxt = op_r == SFI_OP_SE;
			base_nxt = addr_r & ~ADDR_W'((op_r == SFI_OP_SE) ? {SFI_SECT_W{1'b1}} : {SFI_PAGE_W{1'b1}});
			idx_nxt = '0;
			ph_nxt = 1'b0;
			// rewrite merges old bytes, erases, then programs
			cyc_nxt = (op_r == SFI_OP_PW) ? SFI_LOAD : (op_r == SFI_OP_PP) ? SFI_PROG : SFI_ERASE;
		end else if (cyc_r != SFI_IDLE) begin
			ph_nxt = !ph_r;
			if (ph_r) begin
				unique case (cyc_r)
					SFI_LOAD: buf_ld = !mask_r[idx_r[SFI_PAGE_W-1:0]];
					SFI_ERASE: mem_we = 1'b1;
					SFI_PROG: begin
						mem_we = cop_r == SFI_OP_PW || mask_r[idx_r[SFI_PAGE_W-1:0]];
						mem_wd = (cop_r == SFI_OP_PW) ? buf_q : mem_q & buf_q;
					end
					SFI_IDLE: ;
				endcase
				idx_nxt = idx_r + SFI_SECT_W'(1);
				if (last) begin
					idx_nxt = '0;
					unique case (cyc_r)
						SFI_LOAD: cyc_nxt = SFI_ERASE;
						SFI_ERASE: cyc_nxt = (cop_r == SFI_OP_PW) ? SFI_PROG : SFI_IDLE;
						SFI_PROG: cyc_nxt = SFI_IDLE;
						SFI_IDLE: ;
					endcase
					cyc_done = cyc_nxt == SFI_IDLE;
				end
			end
		end
		if (!sync_r.rst_n) begin
			// abort: the page or sector is left part written
			cyc_nxt = SFI_IDLE;
			mem_we = 1'b0;
			buf_ld = 1'b0;
			cyc_done = 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			cyc_r <= SFI_IDLE;
			idx_r <= '0;
			base_r <= '0;
			cop_r <= '0;
			sect_r <= 1'b0;
			ph_r <= 1'b0;
		end else begin
			cyc_r <= cyc_nxt;
			idx_r <= idx_nxt;
			base_r <= base_nxt;
			cop_r <= cop_nxt;
			sect_r <= sect_nxt;
			ph_r <= ph_nxt;
		end
	end

	assign rd_addr = (cyc_r != SFI_IDLE) ? waddr : addr_r;

	always_ff @(posedge CLK_I) begin
		mem_q <= mem_r[rd_addr];
		buf_q <= buf_r[idx_r[SFI_PAGE_W-1:0]];
		if (mem_we) begin
			mem_r[waddr] <= mem_wd;
		end
		if (buf_ld) begin
			buf_r[idx_r[SFI_PAGE_W-1:0]] <= mem_q;
		end else if (drain) begin
			buf_r[drain_word.idx] <= drain_word.data;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I || cyc_done || !sync_r.rst_n || (cs_fall && cyc_r == SFI_IDLE && !pend_r)) begin
			mask_r <= '0;
		end else if (drain) begin
			mask_r[drain_word.idx] <= 1'b1;
		end
	end

	assign SO_O = so_r;
	assign SO_OE_O = frame_r && !sync_r.cs_n && sync_r.rst_n;
	assign BUSY_O = cyc_r != SFI_IDLE;
	assign STANDBY_O = sync_r.cs_n && cyc_r == SFI_IDLE && !pend_r;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence pw_start_s;
		cyc_start && op_r == SFI_OP_PW;
	endsequence

	desel_hiz_a: assert property (sync_r.cs_n |-> !SO_OE_O) else $error("output driven while deselected");
	reset_hiz_a: assert property (!sync_r.rst_n |-> !SO_OE_O ##1 !frame_r) else $error("output driven in reset");
	reset_abort_a: assert property (!sync_r.rst_n |=> cyc_r == SFI_IDLE && !pend_r) else $error("cycle not aborted");
	so_on_fall_a: assert property (so_r != $past(so_r) |-> $past(sck_fall)) else $error("output changed off falling edge");
	sample_on_rise_a: assert property (bit_r != $past(bit_r) && !$past(cs_fall) |-> $past(sck_rise)) else $error("input sampled off rising edge");
	rewrite_order_a: assert property (pw_start_s |=> cyc_r == SFI_LOAD ##[1:600] cyc_r == SFI_ERASE) else $error("rewrite did not erase");
	protect_low_a: assert property (mem_we |-> sync_r.wp_n || waddr[ADDR_W-1:SFI_PROT_W] != '0) else $error("protected write");
	protect_high_a: assert property (pend_r && !fifo_out_valid && cyc_r == SFI_IDLE && sync_r.rst_n && sync_r.wp_n |=> BUSY_O) else $error("unprotected refused");
	page_span_a: assert property (cyc_r == SFI_PROG && ph_r |-> waddr[ADDR_W-1:SFI_PAGE_W] == base_r[ADDR_W-1:SFI_PAGE_W]) else $error("program left page");
	standby_idle_a: assert property (STANDBY_O |-> cyc_r == SFI_IDLE && sync_r.cs_n) else $error("standby while busy");
	frame_open_a: assert property ($rose(frame_r) |-> $past(cs_fall)) else $error("frame without select fall");
endmodule
